// ==== can_msg_object_ctrl.sv ====
`timescale 1ns/1ps
// Function
// - Control registers hold four true/complement pairs.
// - Pair write 01 clears, 10 sets, 11 keeps.
// - Store over unread data sets overwritten pair.
// - Host updating blocks remote-triggered transmission.
// - Reception store sets fresh payload pair.
// - Eight payload bytes per object, written on store.
// - Unused payload bytes take changing values.
// - All sources merge onto one request line.
// - Status enable gates receive, send, error code.
// - Every valid frame outside initialisation sets reception flag; status request needs status enable.
// - Status plus receive enable gives two requests.
// - Receive enable raises interrupt after reception.
// - Send enable raises interrupt after transmission.
// - Line needs global and source enable.
// - Source code reports highest priority pending source.
// - Object raising interrupt sets its pending pair.
module can_msg_object_ctrl
  import can_obj_pkg::*;
(
  input  wire logic                           clk_in,
  input  wire logic                           resetn_in,
  input  wire logic [can_obj_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [can_obj_pkg::DATA_W-1:0] wr_data_in,
  input  wire logic                           wr_in,
  input  wire logic                           rd_in,
  input  wire logic                           frame_ok_in,
  input  wire logic                           rx_store_in,
  input  wire logic [can_obj_pkg::OBJ_IDX_W-1:0] rx_obj_in,
  input  wire logic [can_obj_pkg::LEN_W-1:0]  rx_len_in,
  input  wire logic [63:0]                    rx_data_in,
  input  wire logic                           tx_done_in,
  input  wire logic [can_obj_pkg::OBJ_IDX_W-1:0] tx_obj_in,
  input  wire logic                           remote_in,
  input  wire logic [can_obj_pkg::OBJ_IDX_W-1:0] remote_obj_in,
  input  wire logic                           lec_update_in,
  input  wire logic [can_obj_pkg::LEC_W-1:0]  lec_in,
  input  wire logic                           bus_isolated_in,
  input  wire logic                           warn_in,
  output logic [can_obj_pkg::DATA_W-1:0]      rd_data_out,
  output logic                                controller_irq_line_out,
  output logic [can_obj_pkg::NUM_OBJ:1]       tx_request_out,
  output logic                                init_out,
  output logic                                config_change_enable_out
);
  import can_obj_pkg::*;

  typedef struct packed {
    logic [7:0]                              ctrl;
    logic                                    frame_received_flag;
    logic                                    frame_sent_flag;
    logic [LEC_W-1:0]                        lec;
    logic                                    bus_isolated;
    logic                                    warn;
    logic                                    stat_pend;
    logic [NUM_OBJ:1][3:0]                   f0;
    logic [NUM_OBJ:1][3:0]                   f1;
    logic [NUM_OBJ:1][NUM_BYTES-1:0][7:0]    data;
    logic [DATA_W-1:0]                       rd_data;
    logic                                    irq;
  } obj_state_s;

  obj_state_s              st_ff;
  obj_state_s              nxt_st;
  logic [DATA_W-1:0]       noise;
  logic [NUM_OBJ:1]        obj_pend;
  logic [OBJ_IDX_W-1:0]    obj_sel;
  logic [3:0]              ofs_sel;
  logic                    obj_hit;
  logic                    run;

  noise_byte_gen #(.W(NOISE_W)) u_noise (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .noise_out (noise)
  );

  function automatic logic [3:0] pair_write(input logic [3:0] old,
                                            input logic [7:0] w);
    pair_write = old;
    for (int i = 0; i < 4; i++) begin
      if (w[2*i +: 2] == PAIR_CLR) begin
        pair_write[i] = 1'b0;
      end else if (w[2*i +: 2] == PAIR_SET) begin
        pair_write[i] = 1'b1;
      end
    end
  endfunction : pair_write

  function automatic logic [7:0] pair_read(input logic [3:0] v);
    pair_read = '0;
    for (int i = 0; i < 4; i++) begin
      pair_read[2*i +: 2] = {v[i], ~v[i]};
    end
  endfunction : pair_read

  function automatic logic [7:0] src_code(input logic s,
                                          input logic [NUM_OBJ:1] p);
    src_code = CODE_NONE;
    for (int i = NUM_OBJ - 1; i >= 1; i--) begin
      if (p[i]) begin
        src_code = CODE_OBJ1 + 8'(i - 1);
      end
    end
    if (p[NUM_OBJ]) begin
      src_code = CODE_OBJ15;
    end
    if (s) begin
      src_code = CODE_STATUS;
    end
  endfunction : src_code

  always_comb begin
    for (int i = 1; i <= NUM_OBJ; i++) begin
      obj_pend[i] = st_ff.f0[i][F0_PEND];
    end
  end

  assign obj_sel = addr_in[7:4];
  assign ofs_sel = addr_in[3:0];
  assign obj_hit = (addr_in[15:8] == OBJ_PAGE) && (obj_sel != '0);
  // Frame traffic stops while software initialisation is active.
  assign run     = !st_ff.ctrl[CTRL_INIT];

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.rd_data = '0;
    // Software accesses come first so that hardware events win.
    if (wr_in) begin
      if (addr_in == CTRL_ADDR) begin
        nxt_st.ctrl = wr_data_in & CTRL_WMASK;
      end else if (addr_in == STAT_ADDR) begin
        nxt_st.frame_received_flag = wr_data_in[ST_FRAME_RECEIVED_FLAG];
        nxt_st.frame_sent_flag = wr_data_in[ST_FRAME_SENT_FLAG];
        nxt_st.lec  = wr_data_in[LEC_W-1:0];
      end else if (obj_hit && ofs_sel == OFS_CON0) begin
        nxt_st.f0[obj_sel] = pair_write(st_ff.f0[obj_sel],
                                        wr_data_in);
      end else if (obj_hit && ofs_sel == OFS_CON1) begin
        nxt_st.f1[obj_sel] = pair_write(st_ff.f1[obj_sel],
                                        wr_data_in);
      end else if (obj_hit && ofs_sel >= OFS_DATA0
                   && ofs_sel <= OFS_DATA7) begin
        nxt_st.data[obj_sel][3'(ofs_sel - OFS_DATA0)] = wr_data_in;
      end
    end
    if (rd_in) begin
      if (addr_in == CTRL_ADDR) begin
        nxt_st.rd_data = st_ff.ctrl;
      end else if (addr_in == STAT_ADDR) begin
        nxt_st.rd_data = {st_ff.bus_isolated, st_ff.warn, 1'b0, st_ff.frame_received_flag,
                          st_ff.frame_sent_flag, st_ff.lec};
        // Reading the status register acknowledges the status source.
        nxt_st.stat_pend = 1'b0;
      end else if (addr_in == CODE_ADDR) begin
        nxt_st.rd_data = src_code(st_ff.stat_pend, obj_pend);
      end else if (obj_hit && ofs_sel == OFS_CON0) begin
        nxt_st.rd_data = pair_read(st_ff.f0[obj_sel]);
      end else if (obj_hit && ofs_sel == OFS_CON1) begin
        nxt_st.rd_data = pair_read(st_ff.f1[obj_sel]);
      end else if (obj_hit && ofs_sel >= OFS_DATA0
                   && ofs_sel <= OFS_DATA7) begin
        nxt_st.rd_data = st_ff.data[obj_sel][3'(ofs_sel - OFS_DATA0)];
      end
    end
    nxt_st.bus_isolated = bus_isolated_in;
    nxt_st.warn   = warn_in;
    if (st_ff.ctrl[CTRL_EIE] && ((bus_isolated_in && !st_ff.bus_isolated)
        || (warn_in && !st_ff.warn))) begin
      nxt_st.stat_pend = 1'b1;
    end
    if (bus_isolated_in && !st_ff.bus_isolated) begin
      nxt_st.ctrl[CTRL_INIT] = 1'b1;
    end
    if (lec_update_in) begin
      nxt_st.lec = lec_in;
      if (st_ff.ctrl[CTRL_SIE]) begin
        nxt_st.stat_pend = 1'b1;
      end
    end
    if (run && frame_ok_in) begin
      nxt_st.frame_received_flag = 1'b1;
      if (st_ff.ctrl[CTRL_SIE]) begin
        nxt_st.stat_pend = 1'b1;
      end
    end
    if (run && rx_store_in && rx_obj_in != '0) begin
      if (st_ff.f1[rx_obj_in][F1_NEW]) begin
        nxt_st.f1[rx_obj_in][F1_LOST] = 1'b1;
      end
      nxt_st.f1[rx_obj_in][F1_NEW] = 1'b1;
      for (int b = 0; b < NUM_BYTES; b++) begin
        if (b < int'(rx_len_in)) begin
          nxt_st.data[rx_obj_in][b] = rx_data_in[8*b +: 8];
        end else begin
          nxt_st.data[rx_obj_in][b] = noise ^ 8'(b);
        end
      end
      if (st_ff.f0[rx_obj_in][F0_RECEIVE_IRQ_ENABLE]) begin
        nxt_st.f0[rx_obj_in][F0_PEND] = 1'b1;
      end
    end
    if (run && tx_done_in && tx_obj_in != '0) begin
      nxt_st.frame_sent_flag = 1'b1;
      nxt_st.f1[tx_obj_in][F1_TXREQ] = 1'b0;
      nxt_st.f1[tx_obj_in][F1_RMT]   = 1'b0;
      if (st_ff.ctrl[CTRL_SIE]) begin
        nxt_st.stat_pend = 1'b1;
      end
      if (st_ff.f0[tx_obj_in][F0_SEND_IRQ_ENABLE]) begin
        nxt_st.f0[tx_obj_in][F0_PEND] = 1'b1;
      end
    end
    if (run && remote_in && remote_obj_in != '0) begin
      nxt_st.f1[remote_obj_in][F1_RMT] = 1'b1;
      if (!st_ff.f1[remote_obj_in][F1_LOST]) begin
        nxt_st.f1[remote_obj_in][F1_TXREQ] = 1'b1;
      end
    end
    nxt_st.irq = st_ff.ctrl[CTRL_IE]
                 && (src_code(st_ff.stat_pend, obj_pend)
                     != CODE_NONE);
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st_ff      <= '0;
      st_ff.ctrl <= CTRL_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    for (int i = 1; i <= NUM_OBJ; i++) begin
      tx_request_out[i] = st_ff.f1[i][F1_TXREQ];
    end
  end
  assign rd_data_out              = st_ff.rd_data;
  assign controller_irq_line_out  = st_ff.irq;
  assign init_out                 = st_ff.ctrl[CTRL_INIT];
  assign config_change_enable_out = st_ff.ctrl[CTRL_CCE];

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  logic con1_wr;
  logic store_go;
  assign con1_wr  = wr_in && obj_hit && ofs_sel == OFS_CON1;
  assign store_go = run && rx_store_in && rx_obj_in != '0;

  property p_pair_set;
    con1_wr && wr_data_in[1:0] == PAIR_SET
    |=> st_ff.f1[$past(obj_sel)][F1_NEW];
  endproperty
  a_pair_set: assert property (p_pair_set)
    else $error("fresh payload pair not set by write");

  property p_pair_read;
    rd_in && obj_hit && ofs_sel == OFS_CON0
    |=> rd_data_out == pair_read($past(st_ff.f0[obj_sel]));
  endproperty
  a_pair_read: assert property (p_pair_read)
    else $error("control pair read form wrong");

  property p_lost;
    store_go && st_ff.f1[rx_obj_in][F1_NEW]
    |=> st_ff.f1[$past(rx_obj_in)][F1_LOST];
  endproperty
  a_lost: assert property (p_lost)
    else $error("overwrite not flagged");

  property p_remote_block;
    run && remote_in && remote_obj_in != '0 && !wr_in
    && st_ff.f1[remote_obj_in][F1_LOST]
    && !st_ff.f1[remote_obj_in][F1_TXREQ]
    |=> !tx_request_out[$past(remote_obj_in)];
  endproperty
  a_remote_block: assert property (p_remote_block)
    else $error("remote frame sent while host updating");

  property p_store_data;
    store_go && rx_len_in != '0
    |=> st_ff.f1[$past(rx_obj_in)][F1_NEW]
        && st_ff.data[$past(rx_obj_in)][0] == $past(rx_data_in[7:0]);
  endproperty
  a_store_data: assert property (p_store_data)
    else $error("received payload not stored");

  property p_rx_both;
    store_go && frame_ok_in && st_ff.ctrl[CTRL_SIE]
    && st_ff.f0[rx_obj_in][F0_RECEIVE_IRQ_ENABLE]
    |=> st_ff.stat_pend && st_ff.f0[$past(rx_obj_in)][F0_PEND];
  endproperty
  a_rx_both: assert property (p_rx_both)
    else $error("reception did not raise both requests");

  property p_tx_irq;
    run && tx_done_in && tx_obj_in != '0
    && st_ff.f0[tx_obj_in][F0_SEND_IRQ_ENABLE]
    |=> st_ff.f0[$past(tx_obj_in)][F0_PEND];
  endproperty
  a_tx_irq: assert property (p_tx_irq)
    else $error("transmission did not raise object request");

  property p_line_gate;
    !st_ff.ctrl[CTRL_IE] |=> !controller_irq_line_out;
  endproperty
  a_line_gate: assert property (p_line_gate)
    else $error("request line high with global enable clear");

  property p_line_on;
    st_ff.ctrl[CTRL_IE] && st_ff.stat_pend
    |=> controller_irq_line_out;
  endproperty
  a_line_on: assert property (p_line_on)
    else $error("pending status did not raise the line");

  property p_code_status;
    rd_in && addr_in == CODE_ADDR && st_ff.stat_pend
    |=> rd_data_out == CODE_STATUS;
  endproperty
  a_code_status: assert property (p_code_status)
    else $error("status source not reported first");

  c_overwrite: cover property (store_go && st_ff.f1[rx_obj_in][F1_NEW]);
  c_remote:    cover property (run && remote_in && remote_obj_in != '0);
  c_irq:       cover property (controller_irq_line_out);
endmodule : can_msg_object_ctrl

// ==== can_obj_pkg.sv ====
package can_obj_pkg;
  localparam int          ADDR_W      = 16;
  localparam int          DATA_W      = 8;
  localparam int          NUM_BYTES   = 8;
  localparam int          OBJ_IDX_W   = 4;
  localparam int          NUM_OBJ     = 15;
  localparam int          LEN_W       = 4;
  localparam int          LEC_W       = 3;
  localparam int          NOISE_W     = 16;
  localparam logic [15:0] NOISE_SEED  = 16'hACE1;
  localparam logic [15:0] NOISE_TAPS  = 16'hB400;

  localparam logic [15:0] CTRL_ADDR   = 16'h1E00;
  localparam logic [15:0] STAT_ADDR   = 16'h1E01;
  localparam logic [15:0] CODE_ADDR   = 16'h1E5F;
  localparam logic [7:0]  OBJ_PAGE    = 8'h1E;
  localparam logic [3:0]  OFS_CON0    = 4'h0;
  localparam logic [3:0]  OFS_CON1    = 4'h1;
  localparam logic [3:0]  OFS_DATA0   = 4'h7;
  localparam logic [3:0]  OFS_DATA7   = 4'hE;

  localparam logic [7:0]  CTRL_RESET  = 8'h01;
  localparam logic [7:0]  CTRL_WMASK  = 8'h4F;
  localparam int          CTRL_CCE    = 6;
  localparam int          CTRL_EIE    = 3;
  localparam int          CTRL_SIE    = 2;
  localparam int          CTRL_IE     = 1;
  localparam int          CTRL_INIT   = 0;

  localparam int          ST_BUS_ISOLATED   = 7;
  localparam int          ST_WARN     = 6;
  localparam int          ST_FRAME_RECEIVED_FLAG     = 4;
  localparam int          ST_FRAME_SENT_FLAG     = 3;

  localparam int          F0_VALID    = 3;
  localparam int          F0_SEND_IRQ_ENABLE     = 2;
  localparam int          F0_RECEIVE_IRQ_ENABLE     = 1;
  localparam int          F0_PEND     = 0;
  localparam int          F1_RMT      = 3;
  localparam int          F1_TXREQ    = 2;
  localparam int          F1_LOST     = 1;
  localparam int          F1_NEW      = 0;

  localparam logic [1:0]  PAIR_CLR    = 2'h1;
  localparam logic [1:0]  PAIR_SET    = 2'h2;

  localparam logic [7:0]  CODE_NONE   = 8'h00;
  localparam logic [7:0]  CODE_STATUS = 8'h01;
  localparam logic [7:0]  CODE_OBJ15  = 8'h02;
  localparam logic [7:0]  CODE_OBJ1   = 8'h03;
endpackage : can_obj_pkg

// ==== far_node.sv ====
`timescale 1ns/1ps
module far_node
  import can_obj_pkg::*;
(
  input  wire logic clk_in,
  output logic        frame_ok_out   = 1'b0,
  output logic        rx_store_out   = 1'b0,
  output logic [3:0]  rx_obj_out     = 4'h0,
  output logic [3:0]  rx_len_out     = 4'h0,
  output logic [63:0] rx_data_out    = 64'h0,
  output logic        tx_done_out    = 1'b0,
  output logic [3:0]  tx_obj_out     = 4'h0,
  output logic        remote_out     = 1'b0,
  output logic [3:0]  remote_obj_out = 4'h0
);
  // Released index and data lines are inverted so stale values never match.
  task automatic store(input logic [3:0] o, input logic [3:0] n,
                       input logic [63:0] d);
    @(posedge clk_in);
    rx_obj_out   <= o;
    rx_len_out   <= n;
    rx_data_out  <= d;
    rx_store_out <= 1'b1;
    frame_ok_out <= 1'b1;
    @(posedge clk_in);
    rx_store_out <= 1'b0;
    frame_ok_out <= 1'b0;
    rx_obj_out   <= ~o;
    rx_data_out  <= ~d;
  endtask : store

  task automatic fire(input logic rem, input logic [3:0] o);
    @(posedge clk_in);
    tx_obj_out     <= o;
    remote_obj_out <= o;
    tx_done_out    <= ~rem;
    remote_out     <= rem;
    @(posedge clk_in);
    tx_done_out    <= 1'b0;
    remote_out     <= 1'b0;
    tx_obj_out     <= ~o;
    remote_obj_out <= ~o;
  endtask : fire
endmodule : far_node

// ==== noise_byte_gen.sv ====
`timescale 1ns/1ps
module noise_byte_gen
  import can_obj_pkg::*;
#(
  parameter int W = can_obj_pkg::NOISE_W
) (
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  output logic [DATA_W-1:0] noise_out
);
  import can_obj_pkg::*;

  typedef struct packed {
    logic [W-1:0] lfsr;
  } noise_state_s;

  noise_state_s st_ff;
  noise_state_s nxt_st;

  // Galois shift register; its value never sticks at zero.
  always_comb begin
    nxt_st = st_ff;
    if (st_ff.lfsr[0]) begin
      nxt_st.lfsr = (st_ff.lfsr >> 1) ^ NOISE_TAPS[W-1:0];
    end else begin
      nxt_st.lfsr = st_ff.lfsr >> 1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st_ff.lfsr <= NOISE_SEED[W-1:0];
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign noise_out = st_ff.lfsr[DATA_W-1:0];
endmodule : noise_byte_gen

// ==== test_can_msg_object_ctrl.sv ====
`timescale 1ns/1ps
module test_can_msg_object_ctrl;
  import can_obj_pkg::*;
  logic        clk_in    = 1'b0;
  logic        resetn_in = 1'b0;
  logic [15:0] addr      = 16'h0;
  logic [7:0]  wdat      = 8'h0;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic        warn      = 1'b0;
  logic        boff      = 1'b0;
  logic        lec_up    = 1'b0;
  logic [2:0]  lec       = 3'h0;
  logic        cce;
  logic        ie_m      = 1'b0;
  logic [15:0] pend_m    = 16'h0;
  logic [7:0]  rdat;
  logic        irq;
  logic        init;
  logic [15:1] txr;
  logic        f_ok, f_st, f_tx, f_rm;
  logic [3:0]  f_ro, f_rl, f_to, f_mo;
  logic [63:0] f_rd, pay;
  int          bad_count = 0;
  int          checked   = 0;

  always #25 clk_in = ~clk_in;

  far_node i_far (.clk_in(clk_in), .frame_ok_out(f_ok),
    .rx_store_out(f_st), .rx_obj_out(f_ro), .rx_len_out(f_rl),
    .rx_data_out(f_rd), .tx_done_out(f_tx), .tx_obj_out(f_to),
    .remote_out(f_rm), .remote_obj_out(f_mo));

  can_msg_object_ctrl i_dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .addr_in(addr), .wr_data_in(wdat), .wr_in(wr), .rd_in(rd),
    .frame_ok_in(f_ok), .rx_store_in(f_st), .rx_obj_in(f_ro),
    .rx_len_in(f_rl), .rx_data_in(f_rd), .tx_done_in(f_tx),
    .tx_obj_in(f_to), .remote_in(f_rm), .remote_obj_in(f_mo),
    .lec_update_in(lec_up), .lec_in(lec), .bus_isolated_in(boff),
    .warn_in(warn), .rd_data_out(rdat), .controller_irq_line_out(irq),
    .tx_request_out(txr), .init_out(init),
    .config_change_enable_out(cce));

  task automatic check(input string n, input logic [7:0] s,
                       input logic [7:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdat <= d;
    wr   <= 1'b1;
    @(posedge clk_in);
    wr   <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input string n, input logic [15:0] a,
                        input logic [7:0] e);
    @(posedge clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_in);
    rd   <= 1'b0;
    #1 check(n, rdat, e);
  endtask : rd_chk

  task automatic settle();
    repeat (3) @(posedge clk_in);
    #1;
  endtask : settle

  // Reference priority: status first, then object 15, then 1 to 14.
  function automatic logic [7:0] exp_code();
    if (pend_m[0]) return 8'h01;
    if (pend_m[15]) return 8'h02;
    for (int i = 1; i < 15; i++) begin
      if (pend_m[i]) return 8'(i + 2);
    end
    return 8'h00;
  endfunction : exp_code

  task automatic chk_src();
    settle();
    check("irq", {7'h0, irq}, {7'h0, ie_m & (|pend_m)});
    rd_chk("code", 16'h1E5F, exp_code());
  endtask : chk_src

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (4000) @(posedge clk_in);
    bad_count++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'hBCD6A33E));
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd_chk("ctrl", 16'h1E00, 8'h01);
    chk_src();
    wr_reg(16'h1E00, 8'hFF);
    rd_chk("ctrl", 16'h1E00, 8'h4F);
    check("cce", {7'h0, cce}, 8'h01);
    rd_chk("hole", 16'h1E02, 8'h00);
    wr_reg(16'h1E5F, 8'hFF);
    wr_reg(16'h1E00, 8'h06);
    ie_m = 1'b1;
    chk_src();
    check("init", {7'h0, init}, 8'h00);
    check("cce", {7'h0, cce}, 8'h00);
    wr_reg(16'h1EE1, 8'hFD);
    rd_chk("con1", 16'h1EE1, 8'h55);
    $display("test control done");
    wr_reg(16'h1E30, 8'hFB);
    rd_chk("con0", 16'h1E30, 8'h59);
    pay = {$urandom, $urandom};
    i_far.store(4'h3, 4'h2, pay);
    pend_m[0] = 1'b1;
    pend_m[3] = 1'b1;
    chk_src();
    rd_chk("con1", 16'h1E31, 8'h56);
    rd_chk("byte0", 16'h1E37, pay[7:0]);
    rd_chk("byte1", 16'h1E38, pay[15:8]);
    rd_chk("stat", 16'h1E01, 8'h10);
    pend_m[0] = 1'b0;
    chk_src();
    i_far.store(4'h3, 4'h1, ~pay);
    pend_m[0] = 1'b1;
    rd_chk("con1", 16'h1E31, 8'h5A);
    wr_reg(16'h1E00, 8'h02);
    rd_chk("stat", 16'h1E01, 8'h10);
    pend_m[0] = 1'b0;
    wr_reg(16'h1E30, 8'hFD);
    pend_m[3] = 1'b0;
    chk_src();
    $display("test receive done");
    wr_reg(16'h1E51, 8'hFB);
    i_far.fire(1'b1, 4'h5);
    settle();
    check("txreq", {7'h0, txr[5]}, 8'h00);
    wr_reg(16'h1E57, 8'hA5);
    rd_chk("byte0", 16'h1E57, 8'hA5);
    wr_reg(16'h1E51, 8'hF6);
    i_far.fire(1'b1, 4'h5);
    settle();
    check("txreq", {7'h0, txr[5]}, 8'h01);
    rd_chk("con1", 16'h1E51, 8'hA6);
    i_far.fire(1'b0, 4'h5);
    chk_src();
    check("txreq", {7'h0, txr[5]}, 8'h00);
    $display("test remote done");
    wr_reg(16'h1E10, 8'hFB);
    wr_reg(16'h1EF0, 8'hEF);
    pay = {$urandom, $urandom};
    i_far.store(4'h1, 4'h8, pay);
    i_far.fire(1'b0, 4'hF);
    pend_m[1]  = 1'b1;
    pend_m[15] = 1'b1;
    chk_src();
    rd_chk("byte7", 16'h1E1E, pay[63:56]);
    wr_reg(16'h1EF0, 8'hFD);
    pend_m[15] = 1'b0;
    chk_src();
    wr_reg(16'h1E00, 8'h00);
    ie_m = 1'b0;
    chk_src();
    wr_reg(16'h1E10, 8'hFD);
    pend_m[1] = 1'b0;
    chk_src();
    $display("test priority done");
    wr_reg(16'h1E00, 8'h0A);
    ie_m = 1'b1;
    @(posedge clk_in);
    warn <= 1'b1;
    pend_m[0] = 1'b1;
    chk_src();
    rd_chk("stat", 16'h1E01, 8'h58);
    pend_m[0] = 1'b0;
    chk_src();
    wr_reg(16'h1E00, 8'h0E);
    @(posedge clk_in);
    lec_up <= 1'b1;
    lec    <= 3'h5;
    @(posedge clk_in);
    lec_up <= 1'b0;
    pend_m[0] = 1'b1;
    chk_src();
    rd_chk("stat", 16'h1E01, 8'h5D);
    i_far.store(4'h0, 4'h0, 64'h0);
    chk_src();
    rd_chk("stat", 16'h1E01, 8'h5D);
    pend_m[0] = 1'b0;
    chk_src();
    @(posedge clk_in);
    boff <= 1'b1;
    pend_m[0] = 1'b1;
    chk_src();
    check("init", {7'h0, init}, 8'h01);
    rd_chk("stat", 16'h1E01, 8'hDD);
    pend_m[0] = 1'b0;
    chk_src();
    $display("test error done");
    give_verdict();
  end
endmodule : test_can_msg_object_ctrl
